/* File: src/temp_comp_params.svh */
// Constants for the temperature compensation and calibration memory block
`ifndef TEMP_COMP_PARAMS_SVH
`define TEMP_COMP_PARAMS_SVH
`define LINE_W 13
`define NUM_LINES 14
`define DATA_ROWS 13
`define DATA_BITS 12
`define PAR_BIT 12
`define COLPAR_LINE 13
`define FLAT_W 156
`define TL_LSB 0
`define TQ_LSB 9
`define T0_LSB 17
`define GAIN_LSB 24
`define OFS_LSB 39
`define LOCK_A 148
`define LOCK_B 149
`define TL_ZERO 10'h0a0
`define TQ_ZERO 9'h080
`define T0_ZERO 10'h030
`define T0_MAX 7'h70
`define GAIN_ZERO 16'h4000
`define OFS_ZERO 16'h4000
`define STC_ONE 32'h00800000
`define STC_Q 23
`define LIN_SHIFT 7
`define HALL_TC_Q 14
`define GAIN_Q 12
`define OUT_SHIFT 2
`define CLK_HZ 20000000
`define WRITE_MS 10
`define ERASE_MS 80
`define FRAME_LAST 5'h13
`define REPLY_BITS 4'hc
`define ROW_INIT 13'h1000
`define COLPAR_INIT 13'h1aaa
`endif

/* File: src/temp_comp_pkg.sv */
// Types for the temperature compensation and calibration memory block
package temp_comp_pkg;
	typedef enum logic [2:0] {
		ST_LOAD = 3'b000,
		ST_RUN = 3'b001,
		ST_ERASE = 3'b010,
		ST_WRITE = 3'b011,
		ST_FAULT = 3'b100
	} state_e;
	typedef enum logic [2:0] {
		CMD_NOP = 3'b000,
		CMD_WR_RAM = 3'b001,
		CMD_RD_RAM = 3'b010,
		CMD_PROG = 3'b011,
		CMD_RELOAD = 3'b100
	} cmd_e;
	typedef struct packed {
		cmd_e cmd;
		logic [3:0] line;
		logic [12:0] data;
	} prog_frame_s;
	typedef struct packed {
		logic signed [15:0] hall;
		logic signed [7:0] temp;
		logic [15:0] hall_tc;
	} sample_s;
	typedef logic [13:0][12:0] mem_t;
endpackage

/* File: src/temp_comp_calib.sv */
// Temperature compensation datapath with parity protected calibration memory
`timescale 1ns/1ns
`include "temp_comp_params.svh"
module temp_comp_calib
	import temp_comp_pkg::*;
#(
	parameter int WRITE_CYC = `WRITE_MS * (`CLK_HZ / 1000),
	parameter int ERASE_CYC = `ERASE_MS * (`CLK_HZ / 1000)
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire sample_s sample_in,
	input wire logic sample_valid,
	input wire logic vdd_prog_pin,
	input wire logic out_pin_i,
	output logic out_pin_o,
	output logic out_pin_oe,
	output logic signed [19:0] out_value,
	output logic out_valid,
	output logic out_stage_en,
	output logic locked,
	output logic ecc_corrected,
	output logic ecc_fault,
	output logic prog_busy
);

	////////////////////////////////////////////////////////////////////////////
	// Shared arithmetic and parity checks
	function automatic logic signed [31:0] mul_q(input logic signed [31:0] a, input logic signed [16:0] b,
		input int sh);
		logic signed [48:0] p;
		p = a * b;
		p = p >>> sh;
		mul_q = p[31:0];
	endfunction

	// Returns {column failures, row failures}
	function automatic logic [25:0] syndrome(input mem_t m);
		logic [12:0] rf;
		logic [12:0] cf;
		logic x;
		rf = '0;
		cf = '0;
		for (int r = 0; r < `DATA_ROWS; r++) begin
			rf[r] = ~(^m[r]);
		end
		for (int c = 0; c < `LINE_W; c++) begin
			x = 1'b0;
			for (int r = 0; r < `NUM_LINES; r++) begin
				x = x ^ m[r][c];
			end
			if (c == `PAR_BIT) begin
				cf[c] = x;
			end else begin
				cf[c] = x ^ c[0];
			end
		end
		syndrome = {cf, rf};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	// 156 setting bits plus 26 parity bits
	mem_t nvm = {`COLPAR_INIT, {`DATA_ROWS{`ROW_INIT}}};
	mem_t ram;
	mem_t fixed;
	state_e state;
	logic [25:0] syn;
	logic fix_single;
	logic fix_fault;
	logic [`FLAT_W-1:0] flat;
	logic [2:0] vdd_sync;
	logic [1:0] dat_sync;
	logic edge_rise;
	logic [4:0] bit_cnt;
	logic [19:0] rx_shift;
	prog_frame_s frame;
	logic exec_pulse;
	logic [12:0] tx_shift;
	logic [3:0] tx_cnt;
	logic [31:0] timer;
	logic [3:0] prog_line;
	logic [12:0] prog_data;
	logic accept;
	logic [3:0] vld;
	logic signed [9:0] dt;
	logic signed [15:0] hall_r;
	logic [15:0] hall_tc_r;
	logic signed [31:0] stc;
	logic signed [31:0] p1;
	logic signed [31:0] p2;
	logic [8:0] lin_code;
	logic [7:0] quad_code;
	logic [6:0] t0_code;
	logic [14:0] gain_code;
	logic [14:0] ofs_code;
	logic signed [9:0] lin_c;
	logic signed [8:0] quad_c;
	logic signed [9:0] t0;
	logic signed [15:0] gain;
	logic signed [15:0] ofs;

	////////////////////////////////////////////////////////////////////////////
	// Non-volatile array, shipped with all-zero settings and valid parity
	// Timed erase then write
	always_ff @(posedge core_clk) begin
		if (state == ST_ERASE && timer == 32'h0) begin
			nvm[prog_line] <= '0;
		end else if (state == ST_WRITE && timer == 32'h0) begin
			nvm[prog_line] <= prog_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Matrix parity check and single-bit correction of the EEPROM image
	always_comb begin
		syn = syndrome(nvm);
		fixed = nvm;
		fix_single = 1'b0;
		fix_fault = 1'b0;
		if (syn != 26'h0) begin
			if ($onehot(syn[12:0]) && $onehot(syn[25:13])) begin
				fix_single = 1'b1;
				for (int r = 0; r < `DATA_ROWS; r++) begin
					for (int c = 0; c < `LINE_W; c++) begin
						if (syn[r] && syn[13 + c]) begin
							fixed[r][c] = ~nvm[r][c];
						end
					end
				end
			end else if (syn[12:0] == 13'h0 && $onehot(syn[25:13])) begin
				// error inside the column parity line
				fix_single = 1'b1;
				for (int c = 0; c < `LINE_W; c++) begin
					if (syn[13 + c]) begin
						fixed[`COLPAR_LINE][c] = ~nvm[`COLPAR_LINE][c];
					end
				end
			end else begin
				fix_fault = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Settings decoded from the RAM copy
	always_comb begin
		flat = '0;
		for (int r = 0; r < `DATA_ROWS; r++) begin
			flat[r * `DATA_BITS +: `DATA_BITS] = ram[r][`DATA_BITS-1:0];
		end
	end

	// coefficients come from the RAM copy
	assign lin_code = flat[`TL_LSB +: 9];
	assign quad_code = flat[`TQ_LSB +: 8];
	assign gain_code = flat[`GAIN_LSB +: 15];
	assign ofs_code = flat[`OFS_LSB +: 15];
	// reference temperature limited to its span
	assign t0_code = (flat[`T0_LSB +: 7] > `T0_MAX) ? `T0_MAX : flat[`T0_LSB +: 7];
	assign lin_c = $signed({1'b0, lin_code}) - $signed(`TL_ZERO);
	assign quad_c = $signed({1'b0, quad_code}) - $signed(`TQ_ZERO);
	assign t0 = $signed({3'b000, t0_code}) - $signed(`T0_ZERO);
	assign gain = $signed({1'b0, gain_code}) - $signed(`GAIN_ZERO);
	assign ofs = $signed({1'b0, ofs_code}) - $signed(`OFS_ZERO);

	////////////////////////////////////////////////////////////////////////////
	// Programming pins: synchronise, edge detect, frame receiver
	always_ff @(posedge core_clk) begin
		if (rst) begin
			vdd_sync <= 3'h0;
			dat_sync <= 2'h0;
		end else begin
			vdd_sync <= {vdd_sync[1:0], vdd_prog_pin};
			dat_sync <= {dat_sync[0], out_pin_i};
		end
	end

	assign edge_rise = vdd_sync[1] && !vdd_sync[2];
	assign frame = prog_frame_s'(rx_shift);

	// bits clocked by supply edges, data on own output pin
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bit_cnt <= 5'h0;
			rx_shift <= 20'h0;
			exec_pulse <= 1'b0;
		end else begin
			exec_pulse <= 1'b0;
			if (!locked && state == ST_RUN && tx_cnt == 4'h0 && !out_pin_oe && edge_rise) begin
				rx_shift <= {rx_shift[18:0], dat_sync[1]};
				if (bit_cnt == `FRAME_LAST) begin
					bit_cnt <= 5'h0;
					exec_pulse <= 1'b1;
				end else begin
					bit_cnt <= bit_cnt + 5'h1;
				end
			end
		end
	end

	// Read reply shifted out MSB first on following supply edges
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_shift <= 13'h0;
			tx_cnt <= 4'h0;
			out_pin_o <= 1'b0;
			out_pin_oe <= 1'b0;
		end else if (exec_pulse && frame.cmd == CMD_RD_RAM && frame.line < 4'(`NUM_LINES)) begin
			out_pin_o <= ram[frame.line][12];
			tx_shift <= {ram[frame.line][11:0], 1'b0};
			tx_cnt <= `REPLY_BITS;
			out_pin_oe <= 1'b1;
		end else if (out_pin_oe && edge_rise) begin
			if (tx_cnt != 4'h0) begin
				out_pin_o <= tx_shift[12];
				tx_shift <= {tx_shift[11:0], 1'b0};
				tx_cnt <= tx_cnt - 4'h1;
			end else begin
				out_pin_o <= 1'b0;
				out_pin_oe <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control state machine
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= ST_LOAD;
			timer <= 32'h0;
			prog_line <= 4'h0;
			prog_data <= 13'h0;
			prog_busy <= 1'b0;
		end else begin
			case (state)
				ST_LOAD: begin
					state <= fix_fault ? ST_FAULT : ST_RUN;
				end
				ST_RUN: begin
					if (exec_pulse && frame.cmd == CMD_PROG && frame.line < 4'(`NUM_LINES)) begin
						state <= ST_ERASE;
						timer <= 32'(ERASE_CYC - 1);
						prog_line <= frame.line;
						prog_data <= ram[frame.line];
						prog_busy <= 1'b1;
					end else if (exec_pulse && frame.cmd == CMD_RELOAD) begin
						state <= ST_LOAD;
					end
				end
				ST_ERASE: begin
					if (timer == 32'h0) begin
						state <= ST_WRITE;
						timer <= 32'(WRITE_CYC - 1);
					end else begin
						timer <= timer - 32'h1;
					end
				end
				ST_WRITE: begin
					if (timer == 32'h0) begin
						state <= ST_RUN;
						prog_busy <= 1'b0;
					end else begin
						timer <= timer - 32'h1;
					end
				end
				ST_FAULT: begin
					state <= ST_FAULT;
				end
				default: begin
					state <= ST_FAULT;
				end
			endcase
		end
	end

	// RAM copy loaded from EEPROM, overwritten by programmer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ram <= '0;
		end else if (state == ST_LOAD) begin
			ram <= fixed;
		end else if (state == ST_RUN && exec_pulse && frame.cmd == CMD_WR_RAM && frame.line < 4'(`NUM_LINES)) begin
			ram[frame.line] <= frame.data;
		end
	end

	// freeze decided from the corrected EEPROM image
	always_ff @(posedge core_clk) begin
		if (rst) begin
			locked <= 1'b0;
			ecc_corrected <= 1'b0;
			ecc_fault <= 1'b0;
			out_stage_en <= 1'b0;
		end else if (state == ST_LOAD) begin
			locked <= fixed[`LOCK_A / `DATA_BITS][`LOCK_A % `DATA_BITS]
				&& fixed[`LOCK_B / `DATA_BITS][`LOCK_B % `DATA_BITS];
			ecc_corrected <= fix_single;
			ecc_fault <= fix_fault;
			// output stage off on uncorrectable error
			out_stage_en <= !fix_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fixed-latency compensation pipeline
	assign accept = sample_valid && state != ST_LOAD && state != ST_FAULT;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			vld <= 4'h0;
			out_valid <= 1'b0;
		end else begin
			vld <= {vld[2:0], accept};
			out_valid <= vld[3];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			dt <= 10'sh0;
			hall_r <= 16'sh0;
			hall_tc_r <= 16'h0;
			stc <= 32'sh0;
			p1 <= 32'sh0;
			p2 <= 32'sh0;
			out_value <= 20'sh0;
		end else begin
			if (accept) begin
				dt <= 10'(sample_in.temp) - t0;
				hall_r <= sample_in.hall;
				hall_tc_r <= sample_in.hall_tc;
			end
			// one plus linear plus quadratic term
			stc <= $signed(`STC_ONE) + (32'(lin_c) * 32'(dt) <<< `LIN_SHIFT) + 32'(quad_c) * (32'(dt) * 32'(dt));
			p1 <= mul_q(stc, 17'(hall_r), `STC_Q);
			p2 <= mul_q(p1, $signed({1'b0, hall_tc_r}), `HALL_TC_Q);
			// quartered product of scale 4096 plus offset, same edge as out_valid
			out_value <= 20'((mul_q(p2, 17'(gain), `GAIN_Q) >>> `OUT_SHIFT) + 32'(ofs));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence prog_cmd_s;
		state == ST_RUN && exec_pulse && frame.cmd == CMD_PROG && frame.line < 4'(`NUM_LINES);
	endsequence
	sequence erase_start_s;
		state == ST_ERASE && timer == 32'(ERASE_CYC - 1);
	endsequence

	load_fault_a: assert property (@(posedge core_clk) disable iff (rst)
		state == ST_LOAD && fix_fault |=> state == ST_FAULT ##1 !out_stage_en && ecc_fault)
		else $error("uncorrectable image did not stop output");
	fault_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		state == ST_FAULT |=> state == ST_FAULT && !out_stage_en && !out_valid)
		else $error("fault state left or output active");
	single_fix_a: assert property (@(posedge core_clk) disable iff (rst)
		state == ST_LOAD && fix_single |=> ecc_corrected && syndrome(ram) == 26'h0)
		else $error("single bit error not corrected");
	parity_ok_a: assert property (@(posedge core_clk) disable iff (rst)
		state == ST_LOAD && !fix_fault |=> syndrome(ram) == 26'h0)
		else $error("loaded copy breaks matrix parity");
	locked_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
		locked |-> !exec_pulse && !out_pin_oe)
		else $error("locked device took a programming frame");
	freeze_mem_a: assert property (@(posedge core_clk) disable iff (rst)
		locked && state == ST_RUN |=> $stable(ram) && state != ST_ERASE)
		else $error("frozen memory changed");
	erase_entry_a: assert property (@(posedge core_clk) disable iff (rst)
		prog_cmd_s |=> erase_start_s)
		else $error("program command did not start erase");
	erase_end_a: assert property (@(posedge core_clk) disable iff (rst)
		state == ST_ERASE && timer == 32'h0 |=> state == ST_WRITE && timer == 32'(WRITE_CYC - 1))
		else $error("erase pulse length wrong");
	pipe_latency_a: assert property (@(posedge core_clk) disable iff (rst)
		accept |-> ##5 out_valid)
		else $error("sample result not on time");
	unity_stc_a: assert property (@(posedge core_clk) disable iff (rst)
		vld[0] && dt == 10'sh0 |=> stc == $signed(`STC_ONE))
		else $error("factor not one at reference temperature");
	linear_stc_a: assert property (@(posedge core_clk) disable iff (rst)
		vld[0] && dt == 10'sh1 && quad_code == 8'h80 |=> stc == $signed(`STC_ONE) + $past(32'(lin_c)) * 32'sh80)
		else $error("linear code decode wrong");

endmodule

/* File: bench/calib_prog_model.sv */
// Calibration programmer model on the shared supply pin and each OUT pin
`timescale 1ns/1ns
module calib_prog_model
	import temp_comp_pkg::*;
#(
	parameter int HALF = 8
) (
	input wire logic core_clk,
	output logic vdd_prog_pin,
	output logic [1:0] out_drive,
	input wire logic [1:0] out_pin_o,
	input wire logic [1:0] out_pin_oe
);
	int prog_cycles = 0;
	initial begin
		vdd_prog_pin = 1'b0;
		out_drive = 2'b00;
	end
	////////////////////////////////////////
	// Supply edge clocks each OUT bit
	task automatic bit_out(input logic [1:0] d);
		@(negedge core_clk);
		vdd_prog_pin = 1'b0;
		out_drive = d;
		repeat (HALF) @(negedge core_clk);
		vdd_prog_pin = 1'b1;
		repeat (HALF - 1) @(negedge core_clk);
	endtask
	task automatic send(input logic [1:0] sel, input prog_frame_s f);
		for (int k = 19; k >= 0; k--) begin
			bit_out(sel & {2{f[k]}});
		end
		// Each program command is one cycle
		if (f.cmd == CMD_PROG) begin
			prog_cycles++;
		end
	endtask
	task automatic read_line(input logic [3:0] l, output logic [1:0][12:0] rd, output logic [1:0] seen);
		seen = 2'b11;
		send(2'b11, '{CMD_RD_RAM, l, 13'h0000});
		for (int k = 12; k >= 0; k--) begin
			rd[0][k] = out_pin_o[0];
			rd[1][k] = out_pin_o[1];
			seen = seen & out_pin_oe;
			bit_out(2'b00);
		end
	endtask
endmodule

/* File: bench/testbench.sv */
// Testbench for two compensation devices on one programming link
`timescale 1ns/1ns
module testbench
	import temp_comp_pkg::*;
;
	localparam int WC = 20;
	localparam int EC = 40;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	sample_s sample_in = '0;
	logic sample_valid = 1'b0;
	logic vdd_prog_pin;
	logic [1:0] out_drive, out_pin_i, out_pin_o, out_pin_oe, out_valid, out_stage_en;
	logic [1:0] locked, ecc_corrected, ecc_fault, prog_busy, seen;
	logic signed [19:0] out_value [2];
	logic [155:0] img [2];
	logic [1:0][12:0] rd;
	sample_s s;
	int seed = 7065;
	int n_fail = 0;
	int compares = 0;
	int busy_cnt = 0;
	always #25 core_clk = ~core_clk;
	assign out_pin_i = (out_pin_oe & out_pin_o) | (~out_pin_oe & out_drive);
	always @(posedge core_clk) begin
		busy_cnt <= busy_cnt + prog_busy[0] + prog_busy[1];
	end
	for (genvar g = 0; g < 2; g++) begin : g_dev
		temp_comp_calib #(.WRITE_CYC(WC), .ERASE_CYC(EC)) u_dut (
			.core_clk(core_clk),
			.rst(rst),
			.sample_in(sample_in),
			.sample_valid(sample_valid),
			.vdd_prog_pin(vdd_prog_pin),
			.out_pin_i(out_pin_i[g]),
			.out_pin_o(out_pin_o[g]),
			.out_pin_oe(out_pin_oe[g]),
			.out_value(out_value[g]),
			.out_valid(out_valid[g]),
			.out_stage_en(out_stage_en[g]),
			.locked(locked[g]),
			.ecc_corrected(ecc_corrected[g]),
			.ecc_fault(ecc_fault[g]),
			.prog_busy(prog_busy[g])
		);
	end
	calib_prog_model u_prog (
		.core_clk(core_clk),
		.vdd_prog_pin(vdd_prog_pin),
		.out_drive(out_drive),
		.out_pin_o(out_pin_o),
		.out_pin_oe(out_pin_oe)
	);
	////////////////////////////////////////
	function automatic logic [12:0] line_word(input logic [155:0] f, input int l);
		logic [12:0] w;
		w = '0;
		if (l < 13) begin
			w[11:0] = f[l*12 +: 12];
			w[12] = ~^w[11:0];
		end else begin
			for (int r = 0; r < 13; r++) begin
				w[11:0] = w[11:0] ^ f[r*12 +: 12];
				w[12] = w[12] ^ ~^f[r*12 +: 12];
			end
			w[11:0] = w[11:0] ^ 12'haaa;
		end
		return w;
	endfunction
	function automatic logic [19:0] expect_out(input logic [155:0] f, input sample_s s);
		longint t0;
		longint dt;
		longint p;
		t0 = (f[23:17] > 7'h70) ? 112 : longint'(f[23:17]);
		dt = s.temp - (t0 - 48);
		p = 64'sh800000 + (longint'(f[8:0]) - 160) * dt * 128 + (longint'(f[16:9]) - 128) * dt * dt;
		p = (p * s.hall) >>> 23;
		p = (p * longint'(s.hall_tc)) >>> 14;
		p = (p * (longint'(f[38:24]) - 16384)) >>> 12;
		p = (p >>> 2) + longint'(f[53:39]) - 16384;
		return p[19:0];
	endfunction
	////////////////////////////////////////
	task automatic end_of_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic flags(input logic [9:0] e);
		chk(20'({locked, ecc_corrected, ecc_fault, out_stage_en, prog_busy}), 20'(e));
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask
	task automatic smp(input sample_s s, input logic [1:0] live);
		@(negedge core_clk);
		sample_in = s;
		sample_valid = 1'b1;
		for (int k = 1; k <= 5; k++) begin
			@(negedge core_clk);
			sample_valid = 1'b0;
			chk(20'(out_valid), (k == 5) ? 20'(live) : 20'h0);
		end
		for (int d = 0; d < 2; d++) begin
			if (live[d]) begin
				chk(out_value[d], expect_out(img[d], s));
			end
		end
	endtask
	task automatic prog(input logic [1:0] sel, input logic [3:0] l, input int exp_busy);
		int i;
		busy_cnt = 0;
		u_prog.send(sel, '{CMD_PROG, l, 13'h0000});
		for (i = 0; i < 200 && prog_busy != 2'b00; i++) @(negedge core_clk);
		if (i == 200) begin
			n_fail++;
			end_of_test();
		end
		chk(20'(busy_cnt), 20'(exp_busy));
	endtask
	////////////////////////////////////////
	initial begin
		img[0] = '0;
		img[1] = '0;
		do_reset();
		flags(10'b00_00_00_11_00);
		for (int l = 0; l < 14; l++) begin
			u_prog.read_line(4'(l), rd, seen);
			chk(20'(seen), 20'h3);
			chk(20'(rd[0]), 20'(line_word('0, l)));
			chk(20'(rd[1]), 20'(line_word('0, l)));
		end
		$display("done: shipped image");
		smp(40'h8000_80_ffff, 2'b11);
		smp(40'h7fff_7f_4000, 2'b11);
		for (int n = 0; n < 3; n++) begin
			img[0][53:0] = 54'({$random(seed), $random(seed)});
			img[0][23:17] = (n == 0) ? 7'h70 : (n == 1) ? 7'h00 : 7'($unsigned($random(seed)) % 113);
			for (int l = 0; l < 5; l++) begin
				u_prog.send(2'b01, '{CMD_WR_RAM, 4'(l), line_word(img[0], l)});
			end
			s = 40'({$random(seed), $random(seed)});
			smp(s, 2'b11);
			smp(s, 2'b11);
		end
		u_prog.read_line(4'h2, rd, seen);
		chk(20'(rd[0]), 20'(line_word(img[0], 2)));
		chk(20'(rd[1]), 20'(line_word(img[1], 2)));
		$display("done: compensation");
		u_prog.send(2'b01, '{CMD_WR_RAM, 4'h0, 13'h1008});
		prog(2'b01, 4'h0, EC + WC);
		u_prog.send(2'b01, '{CMD_RELOAD, 4'h0, 13'h0000});
		img[0] = '0;
		flags(10'b00_01_00_11_00);
		u_prog.read_line(4'h0, rd, seen);
		chk(20'(rd[0]), 20'h01000);
		smp(s, 2'b11);
		$display("done: correction");
		img[0][149:148] = 2'b11;
		u_prog.send(2'b01, '{CMD_WR_RAM, 4'hc, line_word(img[0], 12)});
		u_prog.send(2'b01, '{CMD_WR_RAM, 4'hd, line_word(img[0], 13)});
		prog(2'b01, 4'hc, EC + WC);
		prog(2'b01, 4'hd, EC + WC);
		u_prog.send(2'b01, '{CMD_RELOAD, 4'h0, 13'h0000});
		flags(10'b01_01_00_11_00);
		u_prog.send(2'b01, '{CMD_WR_RAM, 4'h1, 13'h0fff});
		prog(2'b01, 4'h1, 0);
		u_prog.read_line(4'h1, rd, seen);
		chk(20'(seen), 20'h2);
		smp(s, 2'b11);
		$display("done: lock");
		u_prog.send(2'b10, '{CMD_WR_RAM, 4'h3, 13'h1001});
		prog(2'b10, 4'h3, EC + WC);
		u_prog.send(2'b10, '{CMD_WR_RAM, 4'h7, 13'h1100});
		prog(2'b10, 4'h7, EC + WC);
		u_prog.send(2'b10, '{CMD_RELOAD, 4'h0, 13'h0000});
		flags(10'b01_01_10_01_00);
		smp(s, 2'b01);
		do_reset();
		flags(10'b01_01_10_01_00);
		smp(s, 2'b01);
		chk(20'(u_prog.prog_cycles > 10), 20'h0);
		$display("done: fault");
		end_of_test();
	end
endmodule
